// ==== inc/rx_decoder_consts.svh ====
// offsets, field positions, reset values and timing counts of the receive decoder
`ifndef RX_DECODER_CONSTS_SVH
`define RX_DECODER_CONSTS_SVH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_DATA 8'h10
`define REG_ERRCNT 8'h14
`define CTRL_DECODER_ENABLE 0
`define CTRL_CHAR_WIDTH_SELECT 1
`define CTRL_SELFTEST_ENABLE_N 2
`define CTRL_FRAMER_ENABLE 3
`define CTRL_RESET 4'h6
`define IRQ_VIOLATION 0
`define IRQ_LOOP_DONE 1
`define IRQ_RESYNC 2
`define IRQ_WIDTH 3
`define BITS_PER_CHAR_NARROW 4'hA
`define BITS_PER_CHAR_WIDE 4'hC
`define SELFTEST_SEED 9'h000
`define SELFTEST_ERR_LIMIT 8
`endif

// ==== inc/rx_decoder_pkg.sv ====
// types shared by the receive decoder
package rx_decoder_pkg;
   typedef enum logic [1:0] {
      ST_HUNT = 2'b01,
      ST_SYNC = 2'b10
   } selftest_state_t;
   typedef enum logic [1:0] {
      SYM_DATA = 2'b00,
      SYM_CMD = 2'b01,
      SYM_BAD = 2'b10
   } sym_kind_t;
endpackage

// ==== design/rx_decoder_bist_checker.sv ====
// receive decoder with bypass, self-test pattern checker and AHB-Lite registers
// Functional notes
// RULE1: decode 10/12-bit characters to data or command
// RULE2: special flag low data, high command
// RULE3: flag invalid or disparity-bad characters
// RULE4: bypass, width high: pass ten bits
// RULE5: bypass, width low: pass twelve bits
// RULE6: self-test turns output register into LFSR
// RULE7: repeating 511-character pseudo-random sequence
// RULE8: far transmitter uses identical shift register
// RULE9: compare each character once synchronized
// RULE10: shift register seeded with data 00
// RULE11: flag mismatch after loop start found
// RULE12: no code violations during self-test
// RULE13: full flag pulses once per loop
// RULE14: many errors: reseed and hunt again
// RULE15: character enable every 10 or 12 bits
// RULE16: framer alignment sets character boundaries
// RULE17: fixed error threshold counted per loop
`include "rx_decoder_consts.svh"
module rx_decoder_bist_checker
   import rx_decoder_pkg::*;
#(
   parameter int ERR_LIMIT = `SELFTEST_ERR_LIMIT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [11:0] framed_char,
   input wire logic framer_align,
   output logic char_strobe,
   output logic [11:0] rx_data_out,
   output logic rx_special_data_flag,
   output logic rx_violation_out,
   output logic rx_violation_alias,
   output logic rx_fifo_full_flag,
   output logic irq
);
   logic [3:0] ctrl;
   logic [`IRQ_WIDTH-1:0] irq_status;
   logic [`IRQ_WIDTH-1:0] irq_mask;
   logic [3:0] bit_cnt;
   logic char_en;
   selftest_state_t st;
   logic [8:0] lfsr;
   logic [7:0] err_cnt;
   logic dp_write;
   logic [7:0] dp_addr;
   logic ev_viol, ev_loop, ev_resync;
   logic decoder_enable, char_width_select, rx_selftest_enable_n, framer_enable;

   assign decoder_enable = ctrl[`CTRL_DECODER_ENABLE];
   assign char_width_select = ctrl[`CTRL_CHAR_WIDTH_SELECT];
   assign rx_selftest_enable_n = ctrl[`CTRL_SELFTEST_ENABLE_N];
   assign framer_enable = ctrl[`CTRL_FRAMER_ENABLE];

   // 5-bit symbol: kind and value (command values J K T R S Q H I = 0..7)
   function automatic logic [5:0] dec5(input logic [4:0] s);
      case (s)
         5'h1E: dec5 = {SYM_DATA, 4'h0};
         5'h09: dec5 = {SYM_DATA, 4'h1};
         5'h14: dec5 = {SYM_DATA, 4'h2};
         5'h15: dec5 = {SYM_DATA, 4'h3};
         5'h0A: dec5 = {SYM_DATA, 4'h4};
         5'h0B: dec5 = {SYM_DATA, 4'h5};
         5'h0E: dec5 = {SYM_DATA, 4'h6};
         5'h0F: dec5 = {SYM_DATA, 4'h7};
         5'h12: dec5 = {SYM_DATA, 4'h8};
         5'h13: dec5 = {SYM_DATA, 4'h9};
         5'h16: dec5 = {SYM_DATA, 4'hA};
         5'h17: dec5 = {SYM_DATA, 4'hB};
         5'h1A: dec5 = {SYM_DATA, 4'hC};
         5'h1B: dec5 = {SYM_DATA, 4'hD};
         5'h1C: dec5 = {SYM_DATA, 4'hE};
         5'h1D: dec5 = {SYM_DATA, 4'hF};
         5'h18: dec5 = {SYM_CMD, 4'h0};
         5'h11: dec5 = {SYM_CMD, 4'h1};
         5'h0D: dec5 = {SYM_CMD, 4'h2};
         5'h07: dec5 = {SYM_CMD, 4'h3};
         5'h19: dec5 = {SYM_CMD, 4'h4};
         5'h00: dec5 = {SYM_CMD, 4'h5};
         5'h04: dec5 = {SYM_CMD, 4'h6};
         5'h1F: dec5 = {SYM_CMD, 4'h7};
         default: dec5 = {SYM_BAD, 4'h0};
      endcase
   endfunction

   // 6-bit symbol: odd-parity top bit marks data, even marks command
   function automatic logic [6:0] dec6(input logic [5:0] s);
      if (s == 6'h00 || s == 6'h3F)
         dec6 = {SYM_BAD, 5'h00};
      else if (s[5] != ^s[4:0])
         dec6 = {SYM_DATA, s[4:0]};
      else
         dec6 = {SYM_CMD, s[4:0]};
   endfunction

   function automatic logic [8:0] lfsr_next(input logic [8:0] v);
      lfsr_next = {v[7:0], ~(v[8] ^ v[4])};
   endfunction

   // character enable from the bit-rate divider; the framer may realign it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_cnt <= 4'h0;
      end else if (framer_enable && framer_align) begin // RULE16
         bit_cnt <= 4'h0;
      end else if (char_en) begin
         bit_cnt <= 4'h0;
      end else begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end
   assign char_en = bit_cnt == (char_width_select ? `BITS_PER_CHAR_NARROW - 4'h1 :
                                `BITS_PER_CHAR_WIDE - 4'h1); // RULE15
   assign char_strobe = char_en;

   // combinational decode
   logic [5:0] hi5, lo5;
   logic [6:0] hi6, lo6;
   logic [11:0] dec_data;
   logic dec_sc, dec_bad;
   always_comb begin
      hi5 = dec5(framed_char[9:5]);
      lo5 = dec5(framed_char[4:0]);
      hi6 = dec6(framed_char[11:6]);
      lo6 = dec6(framed_char[5:0]);
      if (char_width_select) begin // RULE1
         dec_sc = hi5[5:4] == SYM_CMD && lo5[5:4] == SYM_CMD;
         dec_bad = hi5[5:4] == SYM_BAD || lo5[5:4] == SYM_BAD || hi5[5:4] != lo5[5:4];
         dec_data = {4'h0, hi5[3:0], lo5[3:0]};
      end else begin
         dec_sc = hi6[6:5] == SYM_CMD && lo6[6:5] == SYM_CMD;
         dec_bad = hi6[6:5] == SYM_BAD || lo6[6:5] == SYM_BAD || hi6[6:5] != lo6[6:5];
         dec_data = {2'h0, hi6[4:0], lo6[4:0]};
      end
   end

   // self-test sequencer: hunt for the seed, then track and compare
   logic mismatch;
   assign mismatch = {dec_sc, dec_data[7:0]} != lfsr;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= ST_HUNT;
         lfsr <= `SELFTEST_SEED;
         err_cnt <= 8'h00;
      end else if (rx_selftest_enable_n) begin
         st <= ST_HUNT;
         lfsr <= `SELFTEST_SEED; // RULE10
         err_cnt <= 8'h00;
      end else if (char_en) begin // RULE6
         case (st)
            ST_HUNT: begin
               if (!mismatch) begin
                  st <= ST_SYNC;
                  lfsr <= lfsr_next(lfsr); // RULE7
                  err_cnt <= 8'h00;
               end
            end
            ST_SYNC: begin
               if (mismatch && err_cnt == 8'(ERR_LIMIT - 1)) begin // RULE17
                  st <= ST_HUNT; // RULE14
                  lfsr <= `SELFTEST_SEED;
                  err_cnt <= 8'h00;
               end else begin
                  lfsr <= lfsr_next(lfsr);
                  if (lfsr_next(lfsr) == `SELFTEST_SEED)
                     err_cnt <= 8'h00;
                  else if (mismatch)
                     err_cnt <= err_cnt + 8'h01;
               end
            end
            default: begin
               st <= ST_HUNT;
               lfsr <= `SELFTEST_SEED;
            end
         endcase
      end
   end
   assign ev_resync = !rx_selftest_enable_n && char_en && st == ST_SYNC && mismatch &&
                      err_cnt == 8'(ERR_LIMIT - 1);
   // the closing character is compared before the wrap counts as a loop
   assign ev_loop = !rx_selftest_enable_n && char_en && st == ST_SYNC && !ev_resync &&
                    lfsr_next(lfsr) == `SELFTEST_SEED;

   // output register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_data_out <= 12'h000;
         rx_special_data_flag <= 1'b0;
         rx_violation_out <= 1'b0;
      end else if (char_en) begin
         if (!rx_selftest_enable_n) begin
            rx_data_out <= {3'h0, lfsr};
            rx_special_data_flag <= lfsr[8];
            rx_violation_out <= st == ST_SYNC && mismatch; // RULE9 RULE11 RULE12
         end else if (decoder_enable) begin
            rx_data_out <= dec_data;
            rx_special_data_flag <= dec_sc; // RULE2
            rx_violation_out <= dec_bad; // RULE3
         end else begin
            rx_data_out <= char_width_select ? {2'h0, framed_char[9:0]} : framed_char; // RULE4 RULE5
            rx_special_data_flag <= 1'b0;
            rx_violation_out <= 1'b0;
         end
      end
   end
   assign rx_violation_alias = rx_violation_out;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rx_fifo_full_flag <= 1'b0;
      else
         rx_fifo_full_flag <= ev_loop; // RULE13
   end
   assign ev_viol = char_en && rx_violation_out == 1'b0 &&
                    (rx_selftest_enable_n ? decoder_enable && dec_bad : st == ST_SYNC && mismatch);

   // AHB-Lite slave: zero wait states, always OKAY
   logic ap_take;
   assign ap_take = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_write <= ap_take && hwrite;
         dp_addr <= haddr;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_take && !hwrite) begin
         case (haddr)
            `REG_CTRL: hrdata <= {28'h0, ctrl};
            `REG_STATUS: hrdata <= {23'h0, lfsr[8:0]} | {30'h0, st == ST_SYNC, 1'b0} << 12;
            `REG_IRQ_STATUS: hrdata <= {29'h0, irq_status};
            `REG_IRQ_MASK: hrdata <= {29'h0, irq_mask};
            `REG_DATA: hrdata <= {18'h0, rx_violation_out, rx_special_data_flag, rx_data_out};
            `REG_ERRCNT: hrdata <= {24'h0, err_cnt};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `CTRL_RESET;
         irq_mask <= 3'h0;
      end else if (dp_write) begin
         if (dp_addr == `REG_CTRL)
            ctrl <= hwdata[3:0];
         if (dp_addr == `REG_IRQ_MASK)
            irq_mask <= hwdata[`IRQ_WIDTH-1:0];
      end
   end
   // set beats a same-cycle write-one clear
   logic [`IRQ_WIDTH-1:0] irq_set, irq_clr;
   assign irq_set = {ev_resync, ev_loop, ev_viol};
   assign irq_clr = (dp_write && dp_addr == `REG_IRQ_STATUS) ? hwdata[`IRQ_WIDTH-1:0] : 3'h0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_status <= 3'h0;
      else
         irq_status <= (irq_status & ~irq_clr) | irq_set;
   end
   assign irq = |(irq_status & irq_mask);

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_char_bad;
      char_en && rx_selftest_enable_n && decoder_enable && dec_bad;
   endsequence
   sequence s_sync_miss;
      char_en && !rx_selftest_enable_n && st == ST_SYNC && mismatch;
   endsequence

   a_decode_violation: assert property (s_char_bad |=> rx_violation_out) // RULE3
      else $error("bad character not flagged");
   a_special_flag: assert property (char_en && rx_selftest_enable_n && decoder_enable
      |=> rx_special_data_flag == $past(dec_sc)) // RULE2
      else $error("special flag wrong");
   a_bypass_narrow: assert property (char_en && rx_selftest_enable_n && !decoder_enable &&
      char_width_select |=> rx_data_out == {2'h0, $past(framed_char[9:0])}) // RULE4
      else $error("narrow bypass altered data");
   a_bypass_wide: assert property (char_en && rx_selftest_enable_n && !decoder_enable &&
      !char_width_select |=> rx_data_out == $past(framed_char)) // RULE5
      else $error("wide bypass altered data");
   a_miss_flagged: assert property (s_sync_miss |=> rx_violation_out && rx_violation_alias) // RULE11
      else $error("mismatch not flagged");
   a_no_code_flag: assert property (char_en && !rx_selftest_enable_n && !mismatch
      |=> !rx_violation_out) // RULE12
      else $error("self-test flagged a matching character");
   a_loop_pulse: assert property (rx_fifo_full_flag |=> !rx_fifo_full_flag) // RULE13
      else $error("full pulse longer than one cycle");
   a_seed_hold: assert property (rx_selftest_enable_n |=> lfsr == `SELFTEST_SEED) // RULE10
      else $error("seed not held outside self-test");
   a_resync_seed: assert property (ev_resync |=> st == ST_HUNT && lfsr == `SELFTEST_SEED) // RULE14
      else $error("resync did not reseed");
   a_char_period: assert property (char_en && char_width_select && !framer_align
      |=> !char_en [*8] ##1 !char_en) // RULE15
      else $error("character enable too early");

   // a found sync character restarts the divider; otherwise it runs free
   a_realign_restart: assert property (framer_enable && framer_align |=> bit_cnt == 4'h0) // RULE16
      else $error("realignment did not restart the divider");
   a_align_ignored: assert property (!framer_enable && !char_en
      |=> bit_cnt == $past(bit_cnt) + 4'h1) // RULE16
      else $error("divider moved without a realignment");

   // last character of a loop, not ended early by a resync
   sequence s_loop_end;
      char_en && !rx_selftest_enable_n && st == ST_SYNC && !ev_resync &&
         lfsr_next(lfsr) == `SELFTEST_SEED;
   endsequence

   a_loop_flag: assert property (s_loop_end |=> rx_fifo_full_flag) // RULE13
      else $error("completed loop not reported");
   a_loop_only: assert property (!ev_loop |=> !rx_fifo_full_flag) // RULE13
      else $error("full pulse without a completed loop");
   a_seed_restart: assert property (s_loop_end |=> lfsr == `SELFTEST_SEED) // RULE7
      else $error("sequence did not wrap to the seed");
   a_hunt_lock: assert property (char_en && !rx_selftest_enable_n && st == ST_HUNT &&
      !mismatch |=> st == ST_SYNC) // RULE11
      else $error("seed character did not start the compare");
   // no compare errors while still hunting
   a_hunt_quiet: assert property (char_en && !rx_selftest_enable_n && st == ST_HUNT
      |=> !rx_violation_out) // RULE11
      else $error("violation flagged while hunting");
   a_viol_status: assert property (ev_viol |=> irq_status[`IRQ_VIOLATION]) // RULE3
      else $error("violation event not latched");
endmodule

// ==== verification/rx_framer_model.sv ====
// far-side framer model: queued characters, self-test stream, sync fill
module rx_framer_model (
   input wire logic hclk,
   input wire logic char_strobe,
   output logic [11:0] framed_char,
   output logic framer_align,
   output logic took
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] pending[$];
   logic st_mode = 1'b0;
   logic [8:0] lfsr = 9'h000;
   logic [1:0] src = 2'h0;
   logic align_req = 1'b0;
   function automatic logic [4:0] sym(input logic [3:0] n, input logic cmd);
      logic [4:0] d[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
         5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
      logic [4:0] c[8] = '{5'h18, 5'h11, 5'h0D, 5'h07, 5'h19, 5'h00, 5'h04, 5'h1F};
      if (!cmd) return d[n];
      // upper command slots have no code, so they go out invalid
      return n[3] ? 5'h01 : c[n[2:0]];
   endfunction
   // boundaries move only when the bench sets align_req, which drives framer_align
   assign framer_align = align_req;
   initial begin
      took = 1'b0;
      framed_char = 12'h311;
   end
   // src remembers what the decoder sampled, so a late push is never lost
   always @(posedge hclk) begin
      took <= char_strobe && src == 2'h1;
      if (char_strobe && src == 2'h1) pending.delete(0);
      if (char_strobe && src == 2'h2) lfsr = {lfsr[7:0], ~(lfsr[8] ^ lfsr[4])};
      src <= pending.size() > 0 ? 2'h1 : {st_mode, 1'b0};
      // idle fill is the sync pair, as a live link sends between frames
      framed_char <= pending.size() > 0 ? pending[0] : st_mode ?
         {2'h0, sym(lfsr[7:4], lfsr[8]), sym(lfsr[3:0], lfsr[8])} : 12'h311;
   end
endmodule

// ==== verification/rx_decoder_bist_checker_test.sv ====
// self-checking bench: registers, bypass, decode, interrupt, self-test
`include "rx_decoder_consts.svh"
module rx_decoder_bist_checker_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, char_strobe, sdf, viol, viol_copy, full, irq, align, took;
   logic prev_full = 1'b0;
   logic [11:0] fchar, dout, c;
   logic [27:0] expq[$];
   logic [27:0] e;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 32'hA61C;
   int fulls = 0;
   int gap = -1000;
   int per = 10;
   rx_decoder_bist_checker #(.ERR_LIMIT(250)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .framed_char(fchar), .framer_align(align), .char_strobe(char_strobe),
      .rx_data_out(dout), .rx_special_data_flag(sdf), .rx_violation_out(viol),
      .rx_violation_alias(viol_copy), .rx_fifo_full_flag(full), .irq(irq));
   rx_framer_model far (.hclk(hclk), .char_strobe(char_strobe), .framed_char(fchar),
      .framer_align(align), .took(took));
   initial begin
      forever #10 hclk = ~hclk;
   end
   task automatic complete_run;
      if (fail_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         fail_count++;
         complete_run();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      q = hrdata;
      bound(n, 100);
   endtask
   // period checks paused across a width change, the divider keeps its count so the first period is irregular
   task automatic setctrl(input logic [31:0] v, input int p);
      gap = -1000;
      bus(1'b1, `REG_CTRL, v);
      per = p;
      gap = -1000;
   endtask
   task automatic send(input logic [11:0] ch, input logic [13:0] v, input logic [13:0] m);
      @(negedge hclk);
      far.pending.push_back(ch);
      expq.push_back({m, v & m});
   endtask
   task automatic drain;
      int n;
      n = 0;
      while (expq.size() > 0 && n < 1000) begin
         @(posedge hclk);
         n++;
      end
      bound(n, 1000);
   endtask
   task automatic irq_is(input logic v);
      @(negedge hclk);
      check(irq, v);
      @(posedge hclk);
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, `REG_CTRL, 32'h0);
      check(q, 32'h6);
      bus(1'b0, 8'h3C, 32'h0);
      check(q, 32'h0);
      for (int w = 1; w >= 0; w--) begin
         setctrl(w ? 32'h6 : 32'h4, w ? 10 : 12);
         repeat (8) begin
            c = 12'($random(seed));
            send(c, w ? {4'h0, c[9:0]} : {2'h0, c}, 14'h3FFF);
         end
         drain();
      end
      setctrl(32'hE, 10);
      repeat (23) @(posedge hclk);
      far.align_req <= 1'b1;
      @(posedge hclk);
      far.align_req <= 1'b0;
      repeat (30) @(posedge hclk);
      setctrl(32'h7, 10);
      for (int k = 0; k < 16; k++) begin
         c = 12'($random(seed));
         send({2'h0, far.sym(c[7:4], 1'b0), far.sym(c[3:0], 1'b0)}, {6'h0, c[7:0]},
            14'h3FFF);
         send({2'h0, far.sym(4'(k), 1'b1), far.sym(4'(k), 1'b1)},
            k < 8 ? {2'h1, 4'h0, 4'(k), 4'(k)} : 14'h2000,
            k < 8 ? 14'h3FFF : 14'h2000);
      end
      send({2'h0, far.sym(4'h5, 1'b0), far.sym(4'h1, 1'b1)}, 14'h2000, 14'h2000);
      drain();
      irq_is(1'b0);
      bus(1'b1, `REG_IRQ_MASK, 32'h1);
      irq_is(1'b1);
      bus(1'b1, `REG_IRQ_STATUS, 32'h1);
      irq_is(1'b0);
      setctrl(32'h3, 10);
      @(negedge hclk);
      far.lfsr = 9'h000;
      far.st_mode = 1'b1;
      fulls = 0;
      repeat (10260) @(posedge hclk);
      check(fulls, 2);
      complete_run();
   end
   always @(negedge hclk) begin
      gap++;
      if (char_strobe && gap > 0) check(gap, per);
      if (char_strobe) gap = 0;
      if (align) gap = 0;
      check(viol_copy, viol);
      check(full & prev_full, 1'b0);
      if (full) fulls++;
      prev_full = full;
      if (took && expq.size() > 0) begin
         e = expq.pop_front();
         check({viol, sdf, dout} & e[27:14], e[13:0]);
      end
   end
endmodule
